// File: hdl/ptg_map.vh
// constants for the pcs test pattern generator and checker
`ifndef PTG_MAP_VH
`define PTG_MAP_VH
`define PTG_USR_W        64
`define PTG_BLK_W        128
`define PTG_SEED_W       58
`define PTG_SEED_PART_W  16
`define PTG_VERR_W       32
`define PTG_SERR_W       16
`define PTG_SQPW_W       8
`define PTG_SQPW_RST     8'h04
`define PTG_PRBS_TAP_A   30
`define PTG_PRBS_TAP_B   27
`define PTG_PRBS_SYNC_N  6'h20
`define PTG_PRBS_TAPS    3
`endif

// File: hdl/ptg_pattern_gen_check.v
// pcs test pattern generator and checker, one bit per clock on the serial line
//
// Operation
// - offers square, seeded pseudo-random, prbs31 and 64-bit static user pattern
// - both error counters saturate and clear on read
// - second 32-bit error counter exposed as low and high halves
// - square wave sent when select and generator enable both set and user pattern enable is clear
// - square half period follows square period register in bit times
// - no checker and no error counting for square wave
// - select cleared gives pseudo-random pattern
// - data select cleared: revolving four blocks of 128 bits
// - blocks scrambled from seed a, not seed a, seed b, not seed b
// - generator runs only when enabled; random analyzer only when analyzer enabled, user analyzer follows generator enable
// - pseudo-random errors count once per errored block
// - prbs31 ability flag reads one after reset
// - prbs31 generator and checker have separate enables
// - prbs31 checker adds one per mismatch, on arrival and at each of its two taps, three per flip
// - user pattern enable plus generator enable runs user generator and analyzer
`default_nettype none
`include "ptg_map.vh"
module ptg_pattern_gen_check #(
    parameter SQPW_W = `PTG_SQPW_W,
    parameter SEED_W = `PTG_SEED_W
) (
    // clock and reset
    input  wire                   sys_clk,
    input  wire                   rstn,
    // control
    input  wire                   square_wave_select,
    input  wire                   pattern_generator_enable,
    input  wire                   pattern_analyzer_enable,
    input  wire [SQPW_W-1:0]      square_period_bits,
    input  wire                   random_data_mode_select,
    input  wire [SEED_W-1:0]      scrambler_seed_a,
    input  wire [SEED_W-1:0]      scrambler_seed_b,
    input  wire                   long_prbs_generator_enable,
    input  wire                   long_prbs_checker_enable,
    input  wire [63:0]            static_user_pattern,
    input  wire                   static_user_pattern_enable,
    // counter read strobes, one cycle each
    input  wire                   std_count_read,
    input  wire                   vendor_count_read,
    // serial line
    output reg                    tx_bit,
    input  wire                   rx_bit,
    // status
    output reg  [15:0]            std_test_error_count,
    output reg  [15:0]            vendor_error_count_low,
    output reg  [15:0]            vendor_error_count_high,
    output reg                    long_prbs_ability_flag,
    output reg                    long_prbs_locked
);
    localparam M_OFF = 3'h0, M_SQ = 3'h1, M_RND = 3'h2, M_PRBS = 3'h3, M_USR = 3'h4;

    reg         rst_s1_q, rst_s2_q;
    wire        rst_n = rst_s2_q;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // scrambler step, x^58 + x^39 + 1, self-synchronous form
    function [SEED_W:0] scr_step;
        input [SEED_W-1:0] st;
        input              din;
        reg                o;
        begin
            o = din ^ st[38] ^ st[57];
            scr_step = {o, st[SEED_W-2:0], o};
        end
    endfunction

    // prbs31 feedback bit
    function prbs_fb;
        input [30:0] st;
        begin
            prbs_fb = st[`PTG_PRBS_TAP_A] ^ st[`PTG_PRBS_TAP_B];
        end
    endfunction

    // generator mode; the square/random pattern outranks prbs31
    reg  [2:0] tx_mode;
    always @* begin
        tx_mode = M_OFF;
        if (pattern_generator_enable && static_user_pattern_enable)
            tx_mode = M_USR;
        else if (pattern_generator_enable && square_wave_select)
            tx_mode = M_SQ;
        else if (pattern_generator_enable)
            tx_mode = M_RND;
        else if (long_prbs_generator_enable)
            tx_mode = M_PRBS;
    end

    // ---------------- transmit ----------------
    reg [SQPW_W-1:0] sq_cnt_q;
    reg              sq_lvl_q;
    reg [SEED_W-1:0] scr_q;
    reg [6:0]        blk_pos_q;
    reg [1:0]        blk_idx_q;
    reg [30:0]       prbs_q;
    reg [5:0]        usr_pos_q;
    reg [SEED_W:0]   scr_nx;
    reg [SEED_W-1:0] seed_nx;
    reg              tx_d;

    // seed for the block with index i
    function [SEED_W-1:0] seed_sel;
        input [1:0] i;
        begin
            case (i)
                2'd0:    seed_sel = scrambler_seed_a;
                2'd1:    seed_sel = ~scrambler_seed_a;
                2'd2:    seed_sel = scrambler_seed_b;
                default: seed_sel = ~scrambler_seed_b;
            endcase
        end
    endfunction

    always @* begin
        scr_nx  = scr_step(scr_q, 1'b0);
        seed_nx = seed_sel(blk_idx_q + 2'd1);
        case (tx_mode)
            M_SQ:    tx_d = sq_lvl_q;
            M_RND:   tx_d = scr_nx[SEED_W];
            M_PRBS:  tx_d = prbs_fb(prbs_q);
            M_USR:   tx_d = static_user_pattern[usr_pos_q];
            default: tx_d = 1'b0;
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sq_cnt_q  <= {SQPW_W{1'b0}};
            sq_lvl_q  <= 1'b0;
            scr_q     <= {SEED_W{1'b0}};
            blk_pos_q <= 7'h00;
            blk_idx_q <= 2'd0;
            prbs_q    <= 31'h7FFF_FFFF;
            usr_pos_q <= 6'h00;
            tx_bit    <= 1'b0;
        end else begin
            tx_bit <= tx_d;
            // square: level flips every square_period_bits bit times
            if (tx_mode == M_SQ) begin
                if (sq_cnt_q + 1'b1 >= square_period_bits) begin
                    sq_cnt_q <= {SQPW_W{1'b0}};
                    sq_lvl_q <= ~sq_lvl_q;
                end else begin
                    sq_cnt_q <= sq_cnt_q + 1'b1;
                end
            end else begin
                sq_cnt_q <= {SQPW_W{1'b0}};
                sq_lvl_q <= 1'b1;
            end
            if (tx_mode == M_RND) begin
                blk_pos_q <= blk_pos_q + 7'h01;
                if (!random_data_mode_select && blk_pos_q == 7'h7F) begin
                    blk_idx_q <= blk_idx_q + 2'd1;
                    scr_q     <= seed_nx;
                end else begin
                    scr_q <= scr_nx[SEED_W-1:0];
                end
            end else begin
                blk_pos_q <= 7'h00;
                blk_idx_q <= 2'd0;
                scr_q     <= scrambler_seed_a;
            end
            if (tx_mode == M_PRBS)
                prbs_q <= {prbs_q[29:0], prbs_fb(prbs_q)};
            usr_pos_q <= (tx_mode == M_USR) ? usr_pos_q + 6'h01 : 6'h00;
        end
    end

    // ---------------- receive ----------------
    // random check: local scrambler restarts from the same seeds, aligned by block index
    // trade-off: alignment assumes the far end started its pattern with ours
    wire rnd_chk = pattern_analyzer_enable && !square_wave_select
                   && !static_user_pattern_enable;
    wire usr_chk = pattern_generator_enable && static_user_pattern_enable;
    reg  [SEED_W-1:0] rscr_q;
    reg  [6:0]        rpos_q;
    reg  [1:0]        ridx_q;
    reg               blk_err_q;
    // user analyzer compares each bit with the one received 64 bit times earlier,
    // so it needs no alignment to the far end; a wrong but 64-periodic pattern passes
    reg  [6:0]        rusr_q;
    reg  [63:0]       rhist_q;
    reg  [30:0]       rprbs_q;
    reg  [5:0]        sync_q;
    reg  [SEED_W:0]   rscr_nx;
    reg               blk_end;
    reg               usr_err;
    reg  [1:0]        prbs_err;

    always @* begin
        rscr_nx  = scr_step(rscr_q, 1'b0);
        blk_end  = rnd_chk && (rpos_q == 7'h7F) && (blk_err_q || rscr_nx[SEED_W] != rx_bit);
        usr_err  = usr_chk && (rusr_q == 7'h7F) && (rhist_q[63] != rx_bit);
        prbs_err = 2'd0;
        if (long_prbs_checker_enable && long_prbs_locked
            && (prbs_fb(rprbs_q) != rx_bit))
            // one per mismatch: a flipped bit mismatches on arrival and at both taps
            prbs_err = 2'd1;
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rscr_q           <= {SEED_W{1'b0}};
            rpos_q           <= 7'h00;
            ridx_q           <= 2'd0;
            blk_err_q        <= 1'b0;
            rusr_q           <= 7'h00;
            rhist_q          <= 64'h0000_0000_0000_0000;
            rprbs_q          <= 31'h0000_0000;
            sync_q           <= 6'h00;
            long_prbs_locked <= 1'b0;
        end else begin
            if (rnd_chk) begin
                rpos_q <= rpos_q + 7'h01;
                if (rpos_q == 7'h7F) begin
                    blk_err_q <= 1'b0;
                    ridx_q    <= ridx_q + 2'd1;
                    rscr_q    <= random_data_mode_select ? rscr_nx[SEED_W-1:0]
                                                         : seed_sel(ridx_q + 2'd1);
                end else begin
                    blk_err_q <= blk_err_q | (rscr_nx[SEED_W] != rx_bit);
                    rscr_q    <= rscr_nx[SEED_W-1:0];
                end
            end else begin
                rpos_q    <= 7'h00;
                ridx_q    <= 2'd0;
                blk_err_q <= 1'b0;
                rscr_q    <= scrambler_seed_a;
            end
            rhist_q <= {rhist_q[62:0], rx_bit};
            // wait 127 bits so the history holds only a settled line
            if (!usr_chk)
                rusr_q <= 7'h00;
            else if (rusr_q != 7'h7F)
                rusr_q <= rusr_q + 7'h01;
            // prbs checker loads received bits, locks after a clean run
            if (long_prbs_checker_enable) begin
                rprbs_q <= {rprbs_q[29:0], rx_bit};
                if (prbs_fb(rprbs_q) != rx_bit)
                    sync_q <= 6'h00;
                else if (sync_q != `PTG_PRBS_SYNC_N)
                    sync_q <= sync_q + 6'h01;
                if (sync_q == `PTG_PRBS_SYNC_N)
                    long_prbs_locked <= 1'b1;
            end else begin
                sync_q           <= 6'h00;
                long_prbs_locked <= 1'b0;
            end
        end
    end

    // ---------------- counters ----------------
    // read clears, but an error in the read cycle is kept as the new count
    function [15:0] sat16;
        input [15:0] c;
        input [1:0]  inc;
        reg   [16:0] s;
        begin
            s = {1'b0, c} + {15'h0000, inc};
            sat16 = s[16] ? 16'hFFFF : s[15:0];
        end
    endfunction

    wire [1:0]  std_inc = blk_end ? 2'd1 : {1'b0, usr_err};
    wire [31:0] vcnt    = {vendor_error_count_high, vendor_error_count_low};
    wire [32:0] vsum    = {1'b0, vcnt} + {31'h0000_0000, prbs_err | std_inc};
    wire [31:0] vnext   = vsum[32] ? 32'hFFFF_FFFF : vsum[31:0];
    wire [31:0] vclr    = {30'h0000_0000, prbs_err | std_inc};

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            std_test_error_count    <= 16'h0000;
            vendor_error_count_low  <= 16'h0000;
            vendor_error_count_high <= 16'h0000;
            long_prbs_ability_flag  <= 1'b1;
        end else begin
            long_prbs_ability_flag <= 1'b1;
            if (std_count_read)
                std_test_error_count <= {14'h0000, prbs_err | std_inc};
            else
                std_test_error_count <= sat16(std_test_error_count, prbs_err | std_inc);
            if (vendor_count_read)
                {vendor_error_count_high, vendor_error_count_low} <= vclr;
            else
                {vendor_error_count_high, vendor_error_count_low} <= vnext;
        end
    end
endmodule // ptg_pattern_gen_check
`default_nettype wire

// File: bench/ptg_link_partner.sv
// far end of the serial line: loopback with single-bit error injection
`default_nettype none
module ptg_link_partner (
    // clock
    input  wire logic sys_clk,
    // error injection from the bench
    input  wire logic flip_bit,
    // serial line
    input  wire logic tx_bit,
    output var  logic rx_bit
);
    timeunit 1ns;
    timeprecision 1ns;
    initial rx_bit = 1'b0;
    // one cycle of line delay; the user and prbs31 checkers find their own alignment, the random one cannot
    always @(posedge sys_clk) begin
        rx_bit <= tx_bit ^ flip_bit;
    end
endmodule // ptg_link_partner
`default_nettype wire

// File: bench/ptg_check_props.sv
// concurrent checks on the test pattern block ports
`default_nettype none
module ptg_check_props (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rstn,
    // control
    input wire logic        square_wave_select,
    input wire logic        pattern_generator_enable,
    input wire logic        long_prbs_checker_enable,
    input wire logic        static_user_pattern_enable,
    input wire logic        std_count_read,
    input wire logic        vendor_count_read,
    // line and status
    input wire logic        tx_bit,
    input wire logic [15:0] std_test_error_count,
    input wire logic [15:0] vendor_error_count_low,
    input wire logic [15:0] vendor_error_count_high,
    input wire logic        long_prbs_ability_flag,
    input wire logic        long_prbs_locked
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic [6:0] usr_run_q;
    wire [31:0] vnd = {vendor_error_count_high, vendor_error_count_low};
    wire usr_on = pattern_generator_enable & static_user_pattern_enable;
    wire sq_quiet = pattern_generator_enable & square_wave_select & ~usr_on
        & ~long_prbs_checker_enable & ~std_count_read;
    // saturating run length of user mode, so the repeat check waits for a full period
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) usr_run_q <= 7'h00;
        else if (!usr_on) usr_run_q <= 7'h00;
        else if (usr_run_q != 7'h7f) usr_run_q <= usr_run_q + 7'h01;
    end
    a_ability_flag_set: assert property (long_prbs_ability_flag)
        else $error("ability flag low");
    a_std_no_wrap: assert property (!$past(std_count_read) |->
        std_test_error_count >= $past(std_test_error_count))
        else $error("std count dropped");
    a_vendor_no_wrap: assert property (!$past(vendor_count_read) |->
        vnd >= $past(vnd))
        else $error("vendor count dropped");
    a_std_read_clear: assert property (std_count_read |=>
        std_test_error_count <= 16'h0001)
        else $error("std count not cleared");
    a_vendor_read_clear: assert property (vendor_count_read |=> vnd <= 32'h0000_0001)
        else $error("vendor count not cleared");
    a_std_step_one: assert property (!$past(std_count_read) |->
        std_test_error_count - $past(std_test_error_count) <= 16'h0001)
        else $error("std count jumped");
    a_square_no_count: assert property (sq_quiet [*3] |-> $stable(std_test_error_count))
        else $error("square mode counted");
    a_user_repeats: assert property (usr_run_q == 7'h7f |-> tx_bit == $past(tx_bit, 64))
        else $error("user pattern not 64 periodic");
    a_lock_needs_enable: assert property ($rose(long_prbs_locked) |->
        $past(long_prbs_checker_enable, 20))
        else $error("lock without checker enable");
    c_read_nonzero: cover property (std_count_read && std_test_error_count != 16'h0000);
    c_locked: cover property ($rose(long_prbs_locked));
    c_square: cover property (sq_quiet [*3]);
endmodule // ptg_check_props
bind ptg_pattern_gen_check ptg_check_props u_ptg_check_props (
    .sys_clk(sys_clk), .rstn(rstn), .square_wave_select(square_wave_select),
    .pattern_generator_enable(pattern_generator_enable),
    .long_prbs_checker_enable(long_prbs_checker_enable),
    .static_user_pattern_enable(static_user_pattern_enable),
    .std_count_read(std_count_read), .vendor_count_read(vendor_count_read), .tx_bit(tx_bit),
    .std_test_error_count(std_test_error_count),
    .vendor_error_count_low(vendor_error_count_low),
    .vendor_error_count_high(vendor_error_count_high),
    .long_prbs_ability_flag(long_prbs_ability_flag), .long_prbs_locked(long_prbs_locked));
`default_nettype wire

// File: bench/ptg_pattern_gen_check_tb.sv
// self-checking bench for the pcs test pattern block
`default_nettype none
module ptg_pattern_gen_check_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rstn = 0, sel = 0, gen = 0, ana = 0, lgen = 0, lchk = 0, uen = 0;
    logic srd = 0, vrd = 0, flip = 0, rdm = 0, tx, rx, abil, lock;
    logic [7:0] per = 8'h04;
    logic [57:0] sda = 0, sdb = 0, sd;
    logic [63:0] pat = 0, s;
    logic [1023:0] cap;
    logic [15:0] sc, vl, vh;
    int bad_count = 0, samples_checked = 0, cyc = 0, n, m;
    logic t;
    always #25 clk = ~clk;
    ptg_pattern_gen_check u_ptg_pattern_gen_check (.sys_clk(clk), .rstn(rstn),
        .square_wave_select(sel), .pattern_generator_enable(gen),
        .pattern_analyzer_enable(ana), .square_period_bits(per),
        .random_data_mode_select(rdm), .scrambler_seed_a(sda), .scrambler_seed_b(sdb),
        .long_prbs_generator_enable(lgen), .long_prbs_checker_enable(lchk),
        .static_user_pattern(pat), .static_user_pattern_enable(uen),
        .std_count_read(srd), .vendor_count_read(vrd), .tx_bit(tx), .rx_bit(rx),
        .std_test_error_count(sc), .vendor_error_count_low(vl),
        .vendor_error_count_high(vh), .long_prbs_ability_flag(abil),
        .long_prbs_locked(lock));
    ptg_link_partner u_ptg_link_partner (.sys_clk(clk), .flip_bit(flip), .tx_bit(tx),
        .rx_bit(rx));
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    // both counters cleared by one read cycle
    task rd;
        srd <= 1;
        vrd <= 1;
        tick(1);
        srd <= 0;
        vrd <= 0;
        tick(2);
    endtask
    // samples settle by the falling edge; drivers stay on the rising one
    task grab(input int k);
        for (int i = 0; i < k; i++) begin
            @(negedge clk);
            cap[i] = tx;
        end
        tick(1);
    endtask
    function automatic logic is_rot(input logic [63:0] v, input logic [63:0] p);
        logic [127:0] d = {p, p};
        for (int k = 0; k < 64; k++) if (v === 64'(d >> k)) return 1;
        return 0;
    endfunction
    // 128 scrambler output bits on an all-zero payload from a preloaded state
    function automatic logic [127:0] scr_blk(input logic [57:0] seed);
        logic [57:0] st;
        logic [127:0] r;
        st = seed;
        for (int k = 0; k < 128; k++) begin
            r[k] = st[38] ^ st[57];
            st = {st[56:0], r[k]};
        end
        return r;
    endfunction
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            test_done;
        end
    end
    initial begin
        void'($urandom(32'h93b0cc66));
        tick(5);
        rstn <= 1;
        tick(4);
        chk(abil, 1);
        sda <= 58'({$urandom, $urandom});
        sdb <= 58'({$urandom, $urandom});
        sel <= 1;
        gen <= 1;
        ana <= 1;
        for (int i = 0; i < 4; i++) begin
            per <= (i == 0) ? 8'h01 : (i == 1) ? 8'h02 : (i == 2) ? 8'hff : 8'($urandom_range(9, 3));
            tick(1);
            n = (per < 2) ? 1 : per;
            tick(2 * n + 3);
            grab(600);
            m = 0;
            while (m < 598 && cap[m] === cap[m + 1]) m++;
            t = cap[m + 1];
            for (int j = m + 1; j < m + 1 + n && j < 600; j++) if (cap[j] !== t) t = 1'bx;
            chk({t, cap[m + 1 + n]}, {cap[m + 1], ~cap[m + 1]});
        end
        chk(sc, 0);
        sel <= 0;
        tick(20);
        grab(1024);
        chk(cap[511:0] === cap[1023:512], 1);
        m = 512;
        for (int k = 0; k < 512; k++) if (cap[k +: 128] === scr_blk(sda)) m = k;
        chk(m < 512, 1);
        for (int b = 1; b < 4; b++) begin
            sd = (b == 1) ? ~sda : (b == 2) ? sdb : ~sdb;
            chk(cap[(m % 512) + 128 * b +: 128] === scr_blk(sd), 1);
        end
        // zero payload: every bit is the xor of the bits 39 and 58 before it
        rdm <= 1;
        tick(70);
        grab(1024);
        t = |cap;
        for (int k = 58; k < 1024; k++) if (cap[k] !== (cap[k - 39] ^ cap[k - 58])) t = 0;
        chk(t, 1);
        // random analyzer off: it assumes the far end restarts with it
        ana <= 0;
        rd;
        for (int i = 0; i < 2; i++) begin
            uen <= 0;
            tick(1);
            pat <= (i == 0) ? 64'h0000_0000_0000_0001 : {$urandom, $urandom};
            uen <= 1;
            tick(200);
            grab(64);
            s = cap[63:0];
            chk(is_rot(s, pat), 1);
        end
        chk(sc, 0);
        // one flipped bit is seen on arrival and again one period later
        flip <= 1;
        tick(1);
        flip <= 0;
        tick(70);
        chk(sc, 2);
        gen <= 0;
        uen <= 0;
        lgen <= 1;
        lchk <= 1;
        n = 0;
        while (lock !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk(lock, 1);
        tick(5);
        rd;
        chk(sc, 0);
        m = $urandom_range(3, 1);
        repeat (m) begin
            flip <= 1;
            tick(1);
            flip <= 0;
            tick(40);
        end
        chk(sc, 3 * m);
        chk({vh, vl}, 3 * m);
        rd;
        chk({vh, vl, sc}, 0);
        test_done;
    end
endmodule // ptg_pattern_gen_check_tb
`default_nettype wire
